/* core/adcc_regs.vh */
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// register offsets (byte wide registers)
`define ADCC_OFS_STATUS_CTRL   3'h0
`define ADCC_OFS_CONFIG        3'h1
`define ADCC_OFS_RESULT_HIGH   3'h2
`define ADCC_OFS_RESULT_LOW    3'h3
`define ADCC_OFS_CMP_HIGH      3'h4
`define ADCC_OFS_CMP_LOW       3'h5

// status / control fields
`define ADCC_SC_FLAG           7
`define ADCC_SC_IRQ_EN         6
`define ADCC_SC_CMP_EN         5
`define ADCC_SC_CMP_GT         4
`define ADCC_SC_CONTINUOUS     3
`define ADCC_SC_ACTIVE         2
`define ADCC_SC_RESET          8'h00

// config fields
`define ADCC_CFG_LONG_SAMPLE   7
`define ADCC_CFG_MODE10        6
`define ADCC_CFG_HW_TRIG       5
`define ADCC_CFG_CLK_HI        1
`define ADCC_CFG_CLK_LO        0
`define ADCC_CFG_RESET         8'h00

// conversion clock source codes
`define ADCC_CLK_BUS           2'h0
`define ADCC_CLK_BUS_DIV2      2'h1
`define ADCC_CLK_ALT           2'h2
`define ADCC_CLK_ASYNC         2'h3

// sample phase in half conversion-clock cycles (3.5 and 23.5 cycles)
`define ADCC_SAMPLE_SHORT_HALF 7
`define ADCC_SAMPLE_LONG_HALF  47
// whole ticks held, rounded up
`define ADCC_SAMPLE_SHORT_TICKS 5'h04
`define ADCC_SAMPLE_LONG_TICKS  5'h18

`endif

/* core/adcc_core.v */
// successive-approximation converter control with compare and low-power handling
//
// Summary of operation
// [R1] compare on: add result to negated compare
// [R2] greater select: flag when result >= compare
// [R3] less select: flag when result < compare
// [R4] satisfied compare loads difference into results
// [R5] failed compare: no flag, results kept
// [R6] interrupt when flag set and enabled
// [R7] interrupt wakes from wait; compare from stop3
// [R8] wait mode never aborts a conversion
// [R9] wait mode accepts hardware and continuous starts
// [R10] all clock sources usable in wait
// [R11] stop3 without async clock aborts to idle
// [R12] stop3 leaves result registers untouched
// [R13] after stop3 abort, new trigger needed
// [R14] input at high reference gives all ones
// [R15] input at low reference gives zero
// [R16] sample 3.5 or 23.5 clock cycles; held 4 or 24 whole ticks here
// [R17] software should set analog pin select
// [R18] compare enable bit selects compare function
// [R19] compare value writes apply next completion
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "adcc_regs.vh"

module adcc_core #(
  parameter LEVEL_WIDTH = 12
) (
  // clock, reset, enable
  input  wire                   clk,
  input  wire                   reset,
  input  wire                   clk_en,
  // register port
  input  wire [2:0]             reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_write,
  input  wire                   reg_read,
  output reg  [7:0]             reg_rdata,
  // analog side, as digitised levels
  input  wire [LEVEL_WIDTH-1:0] analog_level,
  input  wire [LEVEL_WIDTH-1:0] reference_high_pin,
  input  wire [LEVEL_WIDTH-1:0] reference_low_pin,
  // clock sources and trigger
  input  wire                   async_conversion_clock,
  input  wire                   alternate_clock_source,
  input  wire                   hw_trigger,
  // processor power state
  input  wire                   wait_mode,
  input  wire                   stop3_mode,
  // events
  output wire                   converter_irq,
  output wire                   wake_request,
  output wire                   conversion_active
);

  localparam [2:0] ST_IDLE    = 3'b001;
  localparam [2:0] ST_SAMPLE  = 3'b010;
  localparam [2:0] ST_CONVERT = 3'b100;

  // software-visible state
  reg        conversion_complete_flag_reg;
  reg        completion_irq_enable_reg;
  reg        compare_enable_reg;
  reg        compare_greater_select_reg;
  reg        continuous_reg;
  reg        long_sample_select_reg;
  reg        mode10_reg;
  reg        hw_trigger_select_reg;
  reg  [1:0] clock_select_reg;
  reg  [1:0] result_high_reg;
  reg  [7:0] result_low_reg;
  reg  [1:0] compare_value_high;
  reg  [7:0] compare_value_low;

  // sequencer state
  reg  [2:0] state_reg;
  reg  [4:0] sample_count_reg;
  reg  [3:0] bit_index_reg;
  reg  [9:0] trial_reg;
  reg        div2_reg;
  reg        stop3_seen_reg;

  // returns the reference-scaled level of a 10-bit trial code
  function [LEVEL_WIDTH-1:0] dac_level;
    input [LEVEL_WIDTH-1:0] ref_hi;
    input [LEVEL_WIDTH-1:0] ref_lo;
    input [9:0]             code;
    reg   [LEVEL_WIDTH+9:0] prod;
    begin
      prod      = (ref_hi - ref_lo) * code;
      dac_level = ref_lo + prod[LEVEL_WIDTH+9:10];
    end
  endfunction

  wire       sync_clock   = (clock_select_reg != `ADCC_CLK_ASYNC);
  // clocks other than the async one are stopped in stop3
  wire       clocks_halted = stop3_mode && sync_clock;  // see [R11]
  reg        conv_tick;

  always @* begin
    // see [R10]
    case (clock_select_reg)
      `ADCC_CLK_BUS:      conv_tick = 1'b1;
      `ADCC_CLK_BUS_DIV2: conv_tick = div2_reg;
      `ADCC_CLK_ALT:      conv_tick = alternate_clock_source;
      default:            conv_tick = async_conversion_clock;
    endcase
  end

  wire       sc_write     = reg_write && (reg_addr == `ADCC_OFS_STATUS_CTRL);
  // software start only when hardware trigger is not selected
  wire       sw_start     = sc_write && !reg_wdata[`ADCC_SC_ACTIVE] && !hw_trigger_select_reg;
  wire       hw_start     = hw_trigger_select_reg && hw_trigger;  // see [R9]
  wire       idle         = (state_reg == ST_IDLE);
  wire       start        = idle && !clocks_halted && (sw_start || hw_start);

  // last bit step of the approximation: bit 0 in 10-bit mode, bit 2 in 8-bit mode
  wire [3:0] last_bit     = mode10_reg ? 4'h0 : 4'h2;
  wire [LEVEL_WIDTH-1:0] trial_level =
    dac_level(reference_high_pin, reference_low_pin, trial_reg);
  wire       keep_bit     = (analog_level >= trial_level);

  // final code of the approximation in this step
  wire [9:0] sar_code     = keep_bit ? trial_reg : (trial_reg & ~(10'h001 << bit_index_reg));
  // explicit clamps at the references
  wire [9:0] clamped_code = (analog_level >= reference_high_pin) ? 10'h3ff :   // see [R14]
                            (analog_level <= reference_low_pin)  ? 10'h000 :   // see [R15]
                            sar_code;
  wire [9:0] result_code  = mode10_reg ? clamped_code : {2'h0, clamped_code[9:2]};
  wire [9:0] compare_code = mode10_reg ? {compare_value_high, compare_value_low}
                                       : {2'h0, compare_value_low};
  // see [R1]
  wire [9:0] difference   = result_code + (~compare_code + 10'h001);
  wire       is_ge        = (result_code >= compare_code);
  // see [R2] [R3]
  wire       cmp_met      = compare_greater_select_reg ? is_ge : !is_ge;
  wire       finishing    = (state_reg == ST_CONVERT) && conv_tick && (bit_index_reg == last_bit);
  // see [R18]
  wire       deliver      = finishing && (!compare_enable_reg || cmp_met);
  wire [9:0] deliver_code = compare_enable_reg ? difference : result_code;  // see [R4]

  wire [4:0] sample_ticks = long_sample_select_reg ? `ADCC_SAMPLE_LONG_TICKS
                                                   : `ADCC_SAMPLE_SHORT_TICKS;

  // reading the low result clears the flag; a completion in that cycle wins
  wire       flag_clear   = reg_read && (reg_addr == `ADCC_OFS_RESULT_LOW);

  // sequencer
  always @(posedge clk) begin
    if (reset) begin
      state_reg        <= ST_IDLE;
      sample_count_reg <= 5'h00;
      bit_index_reg    <= 4'h9;
      trial_reg        <= 10'h200;
      div2_reg         <= 1'b0;
      stop3_seen_reg   <= 1'b0;
    end else if (clk_en) begin
      div2_reg       <= !div2_reg;
      stop3_seen_reg <= stop3_mode;
      if (clocks_halted && !stop3_seen_reg) begin
        // abort on stop3 entry; restart needs a fresh trigger (see [R11] [R13])
        state_reg <= ST_IDLE;
      end else if (!clocks_halted) begin
        // wait_mode has no effect on progress (see [R8])
        case (state_reg)
          ST_IDLE: begin
            if (start) begin
              state_reg        <= ST_SAMPLE;
              sample_count_reg <= 5'h00;
            end
          end
          ST_SAMPLE: begin
            if (conv_tick) begin
              // see [R16]
              if (sample_count_reg == sample_ticks - 5'h01) begin
                state_reg     <= ST_CONVERT;
                bit_index_reg <= 4'h9;
                trial_reg     <= 10'h200;
              end else begin
                sample_count_reg <= sample_count_reg + 5'h01;
              end
            end
          end
          ST_CONVERT: begin
            if (conv_tick) begin
              if (bit_index_reg == last_bit) begin
                // continuous operation restarts by itself (see [R9])
                if (continuous_reg) begin
                  state_reg        <= ST_SAMPLE;
                  sample_count_reg <= 5'h00;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                trial_reg     <= sar_code | (10'h001 << (bit_index_reg - 4'h1));
                bit_index_reg <= bit_index_reg - 4'h1;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // registers written by software and by completions
  always @(posedge clk) begin
    if (reset) begin
      conversion_complete_flag_reg <= 1'b0;
      completion_irq_enable_reg    <= 1'b0;
      compare_enable_reg           <= 1'b0;
      compare_greater_select_reg   <= 1'b0;
      continuous_reg               <= 1'b0;
      long_sample_select_reg       <= 1'b0;
      mode10_reg                   <= 1'b0;
      hw_trigger_select_reg        <= 1'b0;
      clock_select_reg             <= `ADCC_CLK_BUS;
      result_high_reg              <= 2'h0;
      result_low_reg               <= 8'h00;
      compare_value_high           <= 2'h0;
      compare_value_low            <= 8'h00;
    end else if (clk_en) begin
      if (sc_write) begin
        completion_irq_enable_reg  <= reg_wdata[`ADCC_SC_IRQ_EN];
        compare_enable_reg         <= reg_wdata[`ADCC_SC_CMP_EN];
        compare_greater_select_reg <= reg_wdata[`ADCC_SC_CMP_GT];
        continuous_reg             <= reg_wdata[`ADCC_SC_CONTINUOUS];
      end
      if (reg_write && reg_addr == `ADCC_OFS_CONFIG) begin
        long_sample_select_reg <= reg_wdata[`ADCC_CFG_LONG_SAMPLE];
        mode10_reg             <= reg_wdata[`ADCC_CFG_MODE10];
        hw_trigger_select_reg  <= reg_wdata[`ADCC_CFG_HW_TRIG];
        clock_select_reg       <= reg_wdata[`ADCC_CFG_CLK_HI:`ADCC_CFG_CLK_LO];
      end
      // live values used at completion only (see [R19])
      if (reg_write && reg_addr == `ADCC_OFS_CMP_HIGH)
        compare_value_high <= reg_wdata[1:0];
      if (reg_write && reg_addr == `ADCC_OFS_CMP_LOW)
        compare_value_low <= reg_wdata;
      // results change only on delivery; stop3 never touches them (see [R5] [R12])
      // halted clocks freeze the sequencer, so no delivery either
      if (deliver && !clocks_halted) begin
        result_high_reg              <= deliver_code[9:8];
        result_low_reg               <= deliver_code[7:0];
        conversion_complete_flag_reg <= 1'b1;
      end else if (flag_clear) begin
        conversion_complete_flag_reg <= 1'b0;
      end
    end
  end

  // read data, one cycle after the strobe
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_read) begin
        case (reg_addr)
          `ADCC_OFS_STATUS_CTRL: reg_rdata <= {conversion_complete_flag_reg, completion_irq_enable_reg,
                                               compare_enable_reg, compare_greater_select_reg,
                                               continuous_reg, !idle, 2'h0};
          `ADCC_OFS_CONFIG:      reg_rdata <= {long_sample_select_reg, mode10_reg, hw_trigger_select_reg,
                                               3'h0, clock_select_reg};
          `ADCC_OFS_RESULT_HIGH: reg_rdata <= {6'h00, result_high_reg};
          `ADCC_OFS_RESULT_LOW:  reg_rdata <= result_low_reg;
          `ADCC_OFS_CMP_HIGH:    reg_rdata <= {6'h00, compare_value_high};
          `ADCC_OFS_CMP_LOW:     reg_rdata <= compare_value_low;
          default:               reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // see [R6]
  assign converter_irq     = conversion_complete_flag_reg && completion_irq_enable_reg;
  // only compare events are allowed to wake from stop3 (see [R7])
  assign wake_request      = converter_irq && (wait_mode || (stop3_mode && compare_enable_reg));
  assign conversion_active = !idle;

endmodule

`default_nettype wire

/* tb/adcc_analog_model.sv */
// analog side model: input level, reference levels and async clock ticks
`timescale 1ns/10ps
`default_nettype none
module adcc_analog_model (
  // clock and level choice
  input  wire logic        clk,
  input  wire logic        at_high,
  // analog side
  output logic      [11:0] level,
  output logic      [11:0] ref_hi,
  output logic      [11:0] ref_lo,
  output logic             async_tick
);
  logic [1:0] div_reg = 2'h0;
  assign ref_hi = 12'hc00;
  assign ref_lo = 12'h100;
  // pin taken as analog-selected by software; conversion does not depend on it
  // full swing beyond both references to hit the clamped codes
  assign level = at_high ? 12'hfff : 12'h000;
  always_ff @(posedge clk) div_reg <= div_reg + 2'h1;
  assign async_tick = (div_reg == 2'h3);
endmodule
`default_nettype wire

/* tb/adcc_core_props.sv */
// port checker for the converter control
`timescale 1ns/10ps
`default_nettype none
`include "adcc_regs.vh"
module adcc_core_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       clk_en,
  // register writes
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  // power state
  input wire logic       wait_mode,
  input wire logic       stop3_mode,
  // events
  input wire logic       converter_irq,
  input wire logic       wake_request,
  input wire logic       conversion_active
);
  logic [1:0] sel_reg;
  logic       irq_en_reg;
  logic       cmp_en_reg;
  logic       sync_clk;
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_reg <= 2'h0;
      irq_en_reg <= 1'b0;
      cmp_en_reg <= 1'b0;
    end else if (clk_en && reg_write) begin
      if (reg_addr == `ADCC_OFS_CONFIG) sel_reg <= reg_wdata[1:0];
      if (reg_addr == `ADCC_OFS_STATUS_CTRL) begin
        irq_en_reg <= reg_wdata[`ADCC_SC_IRQ_EN];
        cmp_en_reg <= reg_wdata[`ADCC_SC_CMP_EN];
      end
    end
  end
  assign sync_clk = (sel_reg != `ADCC_CLK_ASYNC);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_IRQ_ENABLE: assert property (converter_irq |-> irq_en_reg) else $error("irq while disabled");
  AST_IRQ_DONE: assert property ($fell(conversion_active) && irq_en_reg && !cmp_en_reg && !stop3_mode
    && !$past(stop3_mode) |-> converter_irq) else $error("no irq on completion");
  AST_WAKE_WAIT: assert property (converter_irq && wait_mode |-> wake_request) else $error("no wake in wait");
  AST_WAKE_STOP3: assert property (converter_irq && stop3_mode && cmp_en_reg |-> wake_request)
    else $error("no wake in stop3");
  AST_WAKE_CAUSE: assert property (wake_request |-> converter_irq && (wait_mode || stop3_mode && cmp_en_reg))
    else $error("wake without cause");
  AST_MIN_BUSY: assert property ($rose(conversion_active) |-> (conversion_active || stop3_mode)[*8])
    else $error("conversion cut short");
  AST_STOP3_ABORT: assert property ($rose(stop3_mode) && clk_en && sync_clk && conversion_active
    |=> !conversion_active ##1 !conversion_active) else $error("stop3 did not abort");
  AST_STOP3_IDLE: assert property (stop3_mode && clk_en && sync_clk |=> !conversion_active)
    else $error("start during stop3");
endmodule
bind adcc_core adcc_core_props u_props (.clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_write, .wait_mode,
  .stop3_mode, .converter_irq, .wake_request, .conversion_active);
`default_nettype wire

/* tb/adcc_core_tb.sv */
// self-checking bench for the converter control
`timescale 1ns/10ps
`default_nettype none
module adcc_core_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        at_high = 1'b1;
  logic        hw_trigger = 1'b0;
  logic        wait_mode = 1'b0;
  logic        stop3_mode = 1'b0;
  logic [7:0]  rd_val;
  logic [9:0]  r;
  logic [9:0]  r0;
  wire  [7:0]  reg_rdata;
  wire  [11:0] level, ref_hi, ref_lo;
  wire         async_tick, irq, wake, active;
  int          bad_count = 0;
  int          total_checks = 0;
  int          n0, n1, n2;
  initial forever #12.5 clk = ~clk;
  adcc_analog_model PARTNER (.clk(clk), .at_high(at_high), .level(level), .ref_hi(ref_hi), .ref_lo(ref_lo),
    .async_tick(async_tick));
  adcc_core DUT (.clk(clk), .reset(reset), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .analog_level(level),
    .reference_high_pin(ref_hi), .reference_low_pin(ref_lo), .async_conversion_clock(async_tick),
    .alternate_clock_source(1'b0), .hw_trigger(hw_trigger), .wait_mode(wait_mode), .stop3_mode(stop3_mode),
    .converter_irq(irq), .wake_request(wake), .conversion_active(active));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // every bus task starts and ends just after an edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk) reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk) reg_read <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // high first: reading the low byte clears the flag
  task automatic rd_res;
    rd(3'h2);
    r[9:8] = rd_val[1:0];
    rd(3'h3);
    r[7:0] = rd_val;
  endtask
  task automatic fin(output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      #1 cyc++;
    end while (active === 1'b1 && cyc < 300);
    if (cyc >= 300) check(1, 0);
  endtask
  task automatic s_limits;
    wr(3'h1, 8'h40);
    wr(3'h0, 8'h00);
    fin(n0);
    rd(3'h0);
    check(rd_val[7], 1);
    rd_res;
    check(r, 10'h3ff);
    rd(3'h0);
    check(rd_val[7], 0);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h00);
    fin(n0);
    rd_res;
    check(r, 10'h0ff);
    at_high <= 1'b0;
    wr(3'h0, 8'h00);
    fin(n0);
    rd_res;
    check(r, 10'h000);
  endtask
  task automatic s_compare;
    at_high <= 1'b1;
    wr(3'h1, 8'h40);
    wr(3'h4, 8'h01);
    wr(3'h5, 8'h00);
    wr(3'h0, 8'h70);
    fin(n0);
    check(irq, 1);
    rd(3'h0);
    check(rd_val[7], 1);
    rd_res;
    check(r, 10'h2ff);
    wr(3'h0, 8'h60);
    fin(n0);
    rd(3'h0);
    check(rd_val[7], 0);
    rd_res;
    check(r, 10'h2ff);
    wr(3'h0, 8'h70);
    wr(3'h4, 8'h03);
    wr(3'h5, 8'hff);
    fin(n0);
    rd_res;
    check(r, 10'h000);
    at_high <= 1'b0;
    wr(3'h0, 8'h60);
    fin(n0);
    rd_res;
    check(r, 10'h001);
  endtask
  task automatic s_timing;
    wr(3'h0, 8'h00);
    fin(n0);
    wr(3'h1, 8'hc0);
    wr(3'h0, 8'h00);
    fin(n1);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h00);
    fin(n2);
    check(10'(n1 - n0), 10'd20);
    check(10'(n0 - n2), 10'd2);
  endtask
  task automatic s_wait;
    wr(3'h1, 8'h41);
    wr(3'h0, 8'h40);
    wait_mode <= 1'b1;
    fin(n0);
    check(wake, 1);
    rd(3'h3);
    check(wake, 0);
    wr(3'h1, 8'h63);
    wr(3'h0, 8'h40);
    hw_trigger <= 1'b1;
    @(posedge clk) hw_trigger <= 1'b0;
    fin(n0);
    check(wake, 1);
    rd_res;
    check(r, 10'h000);
    wr(3'h1, 8'h40);
    wr(3'h0, 8'h48);
    repeat (15) @(posedge clk);
    #1 check(wake, 1);
    check(active, 1);
    rd(3'h3);
    repeat (14) @(posedge clk);
    #1 check(wake, 1);
    wr(3'h0, 8'h04);
    fin(n0);
    check(active, 0);
    wait_mode <= 1'b0;
  endtask
  task automatic s_stop3;
    // full-scale input: a wrongly finished conversion would show in the results
    at_high <= 1'b1;
    wr(3'h1, 8'h40);
    wr(3'h0, 8'h00);
    repeat (5) @(posedge clk);
    #1 stop3_mode <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(active, 0);
    stop3_mode <= 1'b0;
    repeat (20) @(posedge clk);
    #1 check(active, 0);
    rd_res;
    check(r, 10'h000);
    at_high <= 1'b1;
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    // a fresh start is owed after the abort
    wr(3'h0, 8'h70);
    fin(n0);
    stop3_mode <= 1'b1;
    @(posedge clk);
    #1 check(wake, 1);
    stop3_mode <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    s_limits;
    s_compare;
    s_timing;
    s_wait;
    s_stop3;
    complete_run;
  end
  // whole run is several hundred cycles
  initial begin
    #500us;
    bad_count++;
    complete_run;
  end
endmodule
`default_nettype wire
